// >>> design/ppi_regs.vh
// Purpose: Constants for the P/PI mode switch block.
// Assumes: Codes are the low digit of each setting field.
// Notes: Thresholds are upper limits for the setting inputs, plus one force default.
`ifndef PPI_REGS_VH
`define PPI_REGS_VH
`define PPI_CM_SPEED 4'h0
`define PPI_CM_POS 4'h1
`define PPI_CM_FORCE 4'h2
`define PPI_CM_INT_SPD 4'h3
`define PPI_CM_INT_SPD_SPD 4'h4
`define PPI_CM_INT_SPD_POS 4'h5
`define PPI_CM_INT_SPD_FRC 4'h6
`define PPI_CM_POS_SPD 4'h7
`define PPI_CM_POS_FRC 4'h8
`define PPI_CM_FRC_SPD 4'h9
`define PPI_CM_SPD_ZCLAMP 4'ha
`define PPI_CM_POS_INHIBIT 4'hb
`define PPI_MS_FORCE 3'h0
`define PPI_MS_SPEED 3'h1
`define PPI_MS_ACCEL 3'h2
`define PPI_MS_POSERR 3'h3
`define PPI_MS_OFF 3'h4
`define PPI_FORCE_THR_MAX 16'h0320
`define PPI_FORCE_THR_DEF 16'h00c8
`define PPI_SPEED_THR_MAX 16'h2710
`define PPI_ACCEL_THR_MAX 16'h7530
`define PPI_POSERR_THR_MAX 16'h2710
`endif

// >>> design/ppi_mode_switch.v
// Purpose: Choose P or PI operation of the speed loop.
// Assumes: Inputs synchronous to clk; magnitudes are absolute values.
// Notes: Output p_mode_reg is registered, one cycle after its cause.
// Notes on behaviour
// (RULE_01) Select input low gives P, high PI.
// (RULE_02) Pure force control never allows P.
// (RULE_03) Decode control method codes 0 to B.
// (RULE_04) Host allocates select pin for codes 3-B.
// (RULE_05) Auto switch compares quantity against level.
// (RULE_06) Decode switch selection codes 0 to 4.
// (RULE_07) Force above threshold selects P.
// (RULE_08) Speed reference above threshold selects P.
// (RULE_09) Acceleration above threshold selects P.
// (RULE_10) Position error above threshold selects P.
// (RULE_11) Position error detection only in position.
// (RULE_12) I-P speed loop disables auto switch.
// (RULE_13) Otherwise keep or return to PI.
`timescale 1ns/1ps
`include "ppi_regs.vh"
module ppi_mode_switch (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Host select pin, active low
    input wire proportional_select_input_n,
    // Settings
    input wire [3:0] control_method_setting,
    input wire [2:0] mode_switch_condition_select,
    input wire ip_control_select,
    input wire pos_control_active,
    input wire [15:0] force_level_threshold,
    input wire [15:0] speed_level_threshold,
    input wire [15:0] acceleration_level_threshold,
    input wire [15:0] position_error_threshold,
    // Internal quantities (magnitudes)
    input wire [15:0] force_ref_mag,
    input wire [15:0] speed_ref_mag,
    input wire [15:0] accel_ref_mag,
    input wire [15:0] pos_err_mag,
    // Status
    output reg p_mode_reg,
    output reg auto_p_reg,
    output reg prop_allowed_reg,
    output reg method_valid_reg
);

// ----------------------------------------
// Helpers
// ----------------------------------------
// Limits a threshold setting to the top of its legal range.
function [15:0] clip;
    input [15:0] v;
    input [15:0] mx;
    begin
        clip = (v > mx) ? mx : v;
    end
endfunction

// Strict greater-than test of a magnitude against its clipped level.
function over_level;
    input [15:0] mag;
    input [15:0] thr;
    input [15:0] mx;
    begin
        over_level = (mag > clip(thr, mx));
    end
endfunction

// Codes above the last defined method are refused as unknown.
function is_known_method;
    input [3:0] cm;
    begin
        case (cm)
            `PPI_CM_SPEED: is_known_method = 1'b1;
            `PPI_CM_POS: is_known_method = 1'b1;
            `PPI_CM_FORCE: is_known_method = 1'b1;
            `PPI_CM_INT_SPD: is_known_method = 1'b1;
            `PPI_CM_INT_SPD_SPD: is_known_method = 1'b1;
            `PPI_CM_INT_SPD_POS: is_known_method = 1'b1;
            `PPI_CM_INT_SPD_FRC: is_known_method = 1'b1;
            `PPI_CM_POS_SPD: is_known_method = 1'b1;
            `PPI_CM_POS_FRC: is_known_method = 1'b1;
            `PPI_CM_FRC_SPD: is_known_method = 1'b1;
            `PPI_CM_SPD_ZCLAMP: is_known_method = 1'b1;
            `PPI_CM_POS_INHIBIT: is_known_method = 1'b1;
            default: is_known_method = 1'b0;
        endcase
    end
endfunction

// Pure force control and unknown codes never allow proportional operation.
function allows_prop;
    input [3:0] cm;
    begin
        case (cm)
            `PPI_CM_SPEED: allows_prop = 1'b1;
            `PPI_CM_POS: allows_prop = 1'b1;
            `PPI_CM_FORCE: allows_prop = 1'b0;
            `PPI_CM_INT_SPD: allows_prop = 1'b1;
            `PPI_CM_INT_SPD_SPD: allows_prop = 1'b1;
            `PPI_CM_INT_SPD_POS: allows_prop = 1'b1;
            `PPI_CM_INT_SPD_FRC: allows_prop = 1'b1;
            `PPI_CM_POS_SPD: allows_prop = 1'b1;
            `PPI_CM_POS_FRC: allows_prop = 1'b1;
            `PPI_CM_FRC_SPD: allows_prop = 1'b1;
            `PPI_CM_SPD_ZCLAMP: allows_prop = 1'b1;
            `PPI_CM_POS_INHIBIT: allows_prop = 1'b1;
            default: allows_prop = 1'b0;
        endcase
    end
endfunction

// Methods that run position control on their own.
function is_pos_method;
    input [3:0] cm;
    begin
        case (cm)
            `PPI_CM_POS: is_pos_method = 1'b1;
            `PPI_CM_POS_INHIBIT: is_pos_method = 1'b1;
            default: is_pos_method = 1'b0;
        endcase
    end
endfunction

// Switched methods that have a position side, which pos_control_active marks as live.
function has_pos_side;
    input [3:0] cm;
    begin
        case (cm)
            `PPI_CM_INT_SPD_POS: has_pos_side = 1'b1;
            `PPI_CM_POS_SPD: has_pos_side = 1'b1;
            `PPI_CM_POS_FRC: has_pos_side = 1'b1;
            default: has_pos_side = 1'b0;
        endcase
    end
endfunction

// ----------------------------------------
// Level detection
// ----------------------------------------
// Every quantity is compared each cycle; the selector below picks one result.
wire force_over;
wire speed_over;
wire accel_over;
wire poserr_over;

assign force_over = over_level(force_ref_mag, force_level_threshold,
                               `PPI_FORCE_THR_MAX); // RULE_07
assign speed_over = over_level(speed_ref_mag, speed_level_threshold,
                               `PPI_SPEED_THR_MAX); // RULE_08
assign accel_over = over_level(accel_ref_mag, acceleration_level_threshold,
                               `PPI_ACCEL_THR_MAX); // RULE_09
assign poserr_over = over_level(pos_err_mag, position_error_threshold,
                                `PPI_POSERR_THR_MAX); // RULE_10

// ----------------------------------------
// Method decode and switch selection
// ----------------------------------------
reg valid;
reg allowed;
reg pos_mode;
reg auto_p;
wire manual_p;
wire auto_enable;
wire auto_p_next;
wire p_mode_next;

always @* begin
    valid = is_known_method(control_method_setting); // RULE_03
    allowed = allows_prop(control_method_setting); // RULE_02
    pos_mode = is_pos_method(control_method_setting) ||
               (has_pos_side(control_method_setting) && pos_control_active); // RULE_11
    auto_p = 1'b0;
    case (mode_switch_condition_select) // RULE_06
        `PPI_MS_FORCE: begin
            auto_p = force_over; // RULE_07
        end
        `PPI_MS_SPEED: begin
            auto_p = speed_over; // RULE_08
        end
        `PPI_MS_ACCEL: begin
            auto_p = accel_over; // RULE_09
        end
        `PPI_MS_POSERR: begin
            auto_p = pos_mode && poserr_over; // RULE_10 RULE_11
        end
        `PPI_MS_OFF: begin
            auto_p = 1'b0;
        end
        default: begin
            auto_p = 1'b0;
        end
    endcase
end

// ----------------------------------------
// P or PI decision
// ----------------------------------------
// The select pin is honoured for every allowed method; allocation is the host's duty.
assign manual_p = !proportional_select_input_n; // RULE_01 RULE_04
// The automatic switch rests while the speed loop runs I-P control.
assign auto_enable = !ip_control_select; // RULE_12
assign auto_p_next = allowed && auto_enable && auto_p; // RULE_05
// Falls back to PI whenever neither the pin nor a level asks for P.
assign p_mode_next = allowed && (manual_p || auto_p_next); // RULE_01 RULE_13

// ----------------------------------------
// Output registers
// ----------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        p_mode_reg <= 1'b0;
        auto_p_reg <= 1'b0;
        prop_allowed_reg <= 1'b0;
        method_valid_reg <= 1'b0;
    end else begin
        p_mode_reg <= p_mode_next;
        auto_p_reg <= auto_p_next;
        prop_allowed_reg <= allowed;
        method_valid_reg <= valid;
    end
end

endmodule

// >>> tb/ppi_host.sv
// Purpose: Host side of the proportional select pin.
// Assumes: The host has allocated the pin to the select function.
// Notes: A request for P drives the pin low.
`timescale 1ns/1ps
module ppi_host (
    input wire p_req,
    output wire proportional_select_input_n
);
    assign proportional_select_input_n = !p_req;
endmodule

// >>> tb/ppi_mode_switch_sva.sv
// Purpose: Port level checks of the mode switch.
// Assumes: One clock, reset active high.
// Notes: Bound into the design below the module.
`timescale 1ns/1ps
module ppi_sva (
    input wire clk, rst, proportional_select_input_n, ip_control_select,
    input wire [3:0] control_method_setting,
    input wire [2:0] mode_switch_condition_select,
    input wire [15:0] force_level_threshold, force_ref_mag,
    input wire [15:0] speed_level_threshold, speed_ref_mag,
    input wire [15:0] position_error_threshold, pos_err_mag,
    input wire p_mode_reg, auto_p_reg, prop_allowed_reg, method_valid_reg
);
    wire [3:0] cm = control_method_setting;
    wire [2:0] ms = mode_switch_condition_select;
    wire sn = proportional_select_input_n;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_sel; !sn && cm < 4'h2 |=> p_mode_reg; endproperty
    a_sel: assert property (p_sel) else $error("sel");
    property p_frc; cm == 4'h2 |=> !prop_allowed_reg; endproperty
    a_frc: assert property (p_frc) else $error("frc");
    property p_val; cm > 4'hb |=> !method_valid_reg; endproperty
    a_val: assert property (p_val) else $error("val");
    property p_pi; sn && ms > 3'h3 |=> !p_mode_reg; endproperty
    a_pi: assert property (p_pi) else $error("pi");
    property p_ip; ip_control_select |=> !auto_p_reg; endproperty
    a_ip: assert property (p_ip) else $error("ip");
    property p_off; ms > 3'h3 |=> !auto_p_reg; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_lvl; ms == 3'h0 && !ip_control_select && cm < 4'h2 &&
        force_ref_mag > force_level_threshold && force_level_threshold < 16'h0321
        |=> auto_p_reg; endproperty
    a_lvl: assert property (p_lvl) else $error("lvl");
    property p_auto; ms == 3'h1 && !ip_control_select && cm < 4'h2 &&
        speed_ref_mag > speed_level_threshold && speed_level_threshold < 16'h2711
        |=> p_mode_reg; endproperty
    a_auto: assert property (p_auto) else $error("auto");
    property p_perr; ms == 3'h3 && (cm == 4'h0 || cm == 4'h3 || cm == 4'h4 ||
        cm == 4'h6 || cm == 4'h9 || cm == 4'ha) |=> !auto_p_reg; endproperty
    a_perr: assert property (p_perr) else $error("perr");
    property p_perr_hi; ms == 3'h3 && !ip_control_select && (cm == 4'h1 || cm == 4'hb) &&
        pos_err_mag > position_error_threshold && position_error_threshold < 16'h2711
        |=> auto_p_reg; endproperty
    a_perr_hi: assert property (p_perr_hi) else $error("perr_hi");
endmodule
bind ppi_mode_switch ppi_sva chk_u (.clk(clk), .rst(rst),
    .proportional_select_input_n(proportional_select_input_n),
    .ip_control_select(ip_control_select), .control_method_setting(control_method_setting),
    .mode_switch_condition_select(mode_switch_condition_select),
    .force_level_threshold(force_level_threshold), .force_ref_mag(force_ref_mag),
    .speed_level_threshold(speed_level_threshold), .speed_ref_mag(speed_ref_mag),
    .position_error_threshold(position_error_threshold), .pos_err_mag(pos_err_mag),
    .p_mode_reg(p_mode_reg), .auto_p_reg(auto_p_reg), .prop_allowed_reg(prop_allowed_reg),
    .method_valid_reg(method_valid_reg));

// >>> tb/test_ppi_mode_switch.sv
// Purpose: Bench for the mode switch, built from drive and compare steps.
// Assumes: A 40 MHz clock and a host that has the select pin allocated.
// Notes: Each step drives at one edge and compares one cycle later.
`timescale 1ns/1ps
module test_ppi_mode_switch;
    logic clk = 0, rst = 1, rq = 0, ip = 0, pc = 1;
    wire sn, pm, ap, pa, mv;
    logic [3:0] cm = 0;
    logic [2:0] ms = 4;
    logic [15:0] th = 16'h0064;
    logic [15:0] mg [4] = '{default: 16'h0};
    int err_total = 0, num_checks = 0;
    initial forever #12.5 clk = ~clk;
    ppi_host host_u (.p_req(rq), .proportional_select_input_n(sn));
    ppi_mode_switch dut_u (.clk(clk), .rst(rst), .proportional_select_input_n(sn),
        .control_method_setting(cm), .mode_switch_condition_select(ms),
        .ip_control_select(ip), .pos_control_active(pc), .force_level_threshold(th),
        .speed_level_threshold(th), .acceleration_level_threshold(th),
        .position_error_threshold(th), .force_ref_mag(mg[0]), .speed_ref_mag(mg[1]),
        .accel_ref_mag(mg[2]), .pos_err_mag(mg[3]), .p_mode_reg(pm), .auto_p_reg(ap),
        .prop_allowed_reg(pa), .method_valid_reg(mv));
    task chk(input string n, input logic s, input logic e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %b seen %b", n, e, s);
        end
    endtask
    task end_of_test;
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task go(input logic [3:0] c, input logic [2:0] m, input logic r, input logic i,
        input logic p, input int q, input logic [15:0] v, input logic [15:0] t);
        @(posedge clk);
        cm <= c;
        ms <= m;
        rq <= r;
        ip <= i;
        pc <= p;
        th <= t;
        for (int k = 0; k < 4; k++) mg[k] <= (k == q) ? v : 16'h0;
        @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        for (int c = 0; c < 16; c++) begin
            go(c[3:0], 3'h4, 1, 0, 1, 0, 16'h0, 16'h0064);
            chk("p_mode", pm, c != 2 && c < 12);
            chk("allowed", pa, c != 2 && c < 12);
            chk("valid", mv, c < 12);
        end
        for (int m = 0; m < 4; m++) begin
            go(4'h1, m[2:0], 0, 0, 1, m, 16'h0065, 16'h0064);
            chk("auto", ap, 1);
            chk("p_mode", pm, 1);
            go(4'h1, m[2:0], 0, 0, 1, m, 16'h0064, 16'h0064);
            chk("auto", ap, 0);
            chk("p_mode", pm, 0);
        end
        go(4'h1, 3'h0, 0, 0, 1, 0, 16'h00c9, 16'h00c8);
        chk("force_def", ap, 1);
        go(4'h1, 3'h0, 0, 0, 1, 0, 16'h0321, 16'h0400);
        chk("force_clip", ap, 1);
        go(4'h1, 3'h1, 0, 0, 1, 1, 16'h2711, 16'hffff);
        chk("speed_clip", ap, 1);
        go(4'h1, 3'h2, 0, 0, 1, 2, 16'h7531, 16'hffff);
        chk("accel_clip", ap, 1);
        go(4'h0, 3'h3, 0, 0, 1, 3, 16'h0065, 16'h0064);
        chk("auto", ap, 0);
        go(4'h3, 3'h3, 0, 0, 1, 3, 16'h0065, 16'h0064);
        chk("auto", ap, 0);
        go(4'h5, 3'h3, 0, 0, 1, 3, 16'h0065, 16'h0064);
        chk("auto", ap, 1);
        go(4'h5, 3'h3, 0, 0, 0, 3, 16'h0065, 16'h0064);
        chk("auto", ap, 0);
        go(4'h2, 3'h0, 0, 0, 1, 0, 16'h0065, 16'h0064);
        chk("auto", ap, 0);
        chk("p_mode", pm, 0);
        go(4'h1, 3'h0, 0, 1, 1, 0, 16'h0065, 16'h0064);
        chk("auto", ap, 0);
        chk("p_mode", pm, 0);
        go(4'h0, 3'h4, 1, 0, 1, 0, 16'h0, 16'h0064);
        chk("p_mode", pm, 1);
        @(posedge clk);
        rst <= 1;
        rq <= 0;
        @(posedge clk);
        #1;
        chk("rst_p_mode", pm, 0);
        chk("rst_valid", mv, 0);
        @(posedge clk);
        rst <= 0;
        go(4'h0, 3'h4, 1, 0, 1, 0, 16'h0, 16'h0064);
        chk("p_mode", pm, 1);
        end_of_test;
    end
    initial begin
        #20000;
        err_total++;
        end_of_test;
    end
endmodule
